// >>> common/fddma_pkg.sv
// Shared constants for the flash disk DMA request control.
// Assumes one clock domain shared by the device end and the host end.
package fddma_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] CTRL0_OFS = 13'h1078;
    localparam logic [ADDR_W-1:0] CTRL1_OFS = 13'h107A;
    localparam int SCNT_W = 7;
    localparam int REL_W = 10;
    localparam int POL_BIT = 12;
    localparam int EDGE_BIT = 13;
    localparam int PAUSE_BIT = 14;
    localparam int EN_BIT = 15;
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    localparam int CLK_NS = 8;
    localparam int PULSE_NS = 250;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CODE_W = 6;
    localparam logic [CODE_W-1:0] IRQ_NONE = 6'h00;
    localparam logic [CODE_W-1:0] IRQ_DMA_DONE = 6'h05;
    localparam int SECTOR_BYTES = 512;
    localparam int BYTES_PER_CYC = 2;
    localparam int WORDS_PER_SECTOR = SECTOR_BYTES / BYTES_PER_CYC;
    // Host controller register map
    localparam int SW_AW = 8;
    localparam logic [SW_AW-1:0] H_CFG = 8'h00;
    localparam logic [SW_AW-1:0] H_CMD = 8'h04;
    localparam logic [SW_AW-1:0] H_STAT = 8'h08;
    localparam logic [SW_AW-1:0] H_MASK = 8'h0C;
    localparam logic [SW_AW-1:0] H_WORDS = 8'h10;
    localparam logic [SW_AW-1:0] H_PEEK = 8'h14;
    localparam int CFG_REL_LSB = 16;
    localparam int CMD_START = 0;
    localparam int CMD_RESUME = 1;
    localparam int ST_DONE = 0;
    localparam int ST_REQ = 1;
    localparam int ST_W = 2;
endpackage

// >>> common/fddma_if.sv
// Link between the flash disk DMA request logic and the host DMA controller.
// Both ends run on the same clock; the testbench joins them.
`timescale 1ns/1ps
interface fddma_if;
    import fddma_pkg::*;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic xfer_cyc;
    logic transfer_request_out;
    logic done_irq;
    logic [CODE_W-1:0] irq_code;
    modport dev(
        input reg_addr, reg_wdata, reg_wr, reg_rd, xfer_cyc,
        output reg_rdata, transfer_request_out, done_irq, irq_code
    );
    modport host(
        output reg_addr, reg_wdata, reg_wr, reg_rd, xfer_cyc,
        input reg_rdata, transfer_request_out, done_irq, irq_code
    );
endinterface

// >>> core/fddma_dev_end.sv
// Device end: DMA control registers and the transfer request output.
// Assumes the flash data counter and checksum logic sit beside it on
// the same clock and report the countdown and sector ends to it.
//
// How it works
// R01: sector count holds sectors minus one
// R02: decrement sector count on each checksum read
// R03: count shows remaining sectors after checksum fault
// R04: bit 12 chooses request idle and active level
// R05: edge mode pulses request about 250 ns
// R06: level mode releases request at matching countdown
// R07: checksum fault sets pause and halts transfer
// R08: software fixes data then clears pause bit
// R09: enable bit gates every transfer request
// R10: software programs 10-bit release count
// R11: completion reported as interrupt code five
// R12: after last sector no requests until re-enabled
`timescale 1ns/1ps
module fddma_dev_end import fddma_pkg::*; #(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    fddma_if.dev link,
    input wire logic [REL_W-1:0] flash_data_countdown,
    input wire logic checksum_read,
    input wire logic ecc_fault,
    output logic sector_start,
    output logic dma_busy
);
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_XFER} fddma_dst_e;

    generate
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_chk
            $error("PULSE_CYCLES out of range");
        end
    endgenerate

    // Address match, shared by the write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    fddma_dst_e state_r;
    fddma_dst_e state_nxt;
    logic [SCNT_W-1:0] scnt_r;
    logic [REL_W-1:0] rel_r;
    logic en_r;
    logic pause_r;
    logic edge_r;
    logic pol_r;
    logic done_r;
    logic [7:0] pcnt_r;
    logic [DATA_W-1:0] rdata_r;
    logic [CODE_W-1:0] code_r;
    logic start_r;
    logic wr0;
    logic wr1;
    logic sec_end;
    logic last_sec;
    logic rel_hit;
    logic pulse_end;
    logic req_act;

    assign wr0 = link.reg_wr && hit(link.reg_addr, CTRL0_OFS);
    assign wr1 = link.reg_wr && hit(link.reg_addr, CTRL1_OFS);
    // A sector ends when its checksum has been read
    assign sec_end = checksum_read && (state_r != S_IDLE); // R02
    assign last_sec = (scnt_r == '0); // R01
    assign rel_hit = (flash_data_countdown == rel_r); // R06
    assign pulse_end = (pcnt_r == 8'(PULSE_CYCLES - 1)); // R05

    // Next state of the request sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE: begin
                if (en_r && !pause_r && !done_r) begin
                    state_nxt = S_REQ; // R09
                end
            end
            S_REQ: begin
                if (!en_r) begin
                    state_nxt = S_IDLE; // R09
                end else if (sec_end) begin
                    state_nxt = S_IDLE;
                end else if (!pause_r && edge_r && pulse_end) begin
                    state_nxt = S_XFER; // R05
                end else if (!pause_r && !edge_r && rel_hit) begin
                    state_nxt = S_XFER; // R06
                end
            end
            S_XFER: begin
                if (!en_r || sec_end) begin
                    state_nxt = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Pulse width counter; frozen while paused
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pcnt_r <= 8'h00;
        end else if (state_r != S_REQ) begin
            pcnt_r <= 8'h00;
        end else if (!pause_r && !pulse_end) begin
            pcnt_r <= pcnt_r + 8'h01; // R05
        end
    end

    // Sector count: software load wins over the hardware decrement,
    // so a reprogram never lands one short
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scnt_r <= CTRL_RST[SCNT_W-1:0];
        end else if (wr0) begin
            scnt_r <= link.reg_wdata[SCNT_W-1:0]; // R01
        end else if (sec_end && !last_sec) begin
            scnt_r <= scnt_r - 7'h01; // R02 R03
        end
    end

    // Mode bits and release count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_r <= CTRL_RST[EDGE_BIT];
            pol_r <= CTRL_RST[POL_BIT];
            rel_r <= CTRL_RST[REL_W-1:0];
        end else begin
            if (wr0) begin
                edge_r <= link.reg_wdata[EDGE_BIT];
                pol_r <= link.reg_wdata[POL_BIT]; // R04
            end
            if (wr1) begin
                rel_r <= link.reg_wdata[REL_W-1:0]; // R10
            end
        end
    end

    // Enable: cleared by hardware after the last sector
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_r <= CTRL_RST[EN_BIT];
        end else if (wr0) begin
            en_r <= link.reg_wdata[EN_BIT]; // R09
        end else if (sec_end && last_sec) begin
            en_r <= 1'b0; // R12
        end
    end

    // Pause: set by a fault, cleared by writing zero; the set wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pause_r <= CTRL_RST[PAUSE_BIT];
        end else if (ecc_fault && state_r != S_IDLE) begin
            pause_r <= 1'b1; // R07
        end else if (wr0 && !link.reg_wdata[PAUSE_BIT]) begin
            pause_r <= 1'b0; // R08
        end
    end

    // Completion flag; a fresh enable clears it, the set wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
        end else if (sec_end && last_sec) begin
            done_r <= 1'b1; // R12
        end else if (wr0 && link.reg_wdata[EN_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // Interrupt code follows the completion flag
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_r <= IRQ_NONE;
        end else if (sec_end && last_sec) begin
            code_r <= IRQ_DMA_DONE; // R11
        end else if (wr0 && link.reg_wdata[EN_BIT]) begin
            code_r <= IRQ_NONE;
        end
    end

    // One-cycle mark to the flash data counter at each sector start
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_r <= 1'b0;
        end else begin
            start_r <= (state_r == S_IDLE) && (state_nxt == S_REQ);
        end
    end

    // Register read, data in the following cycle; unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 16'h0000;
        end else if (link.reg_rd && hit(link.reg_addr, CTRL0_OFS)) begin
            rdata_r <= {en_r, pause_r, edge_r, pol_r, 5'h00, scnt_r};
        end else if (link.reg_rd && hit(link.reg_addr, CTRL1_OFS)) begin
            rdata_r <= {6'h00, rel_r};
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // Level mode drops the request in the very cycle the countdown
    // matches, hence the combinational term on the countdown input
    assign req_act = (state_r == S_REQ) && en_r && !pause_r
                     && (edge_r || !rel_hit); // R06 R07 R09
    assign link.transfer_request_out = pol_r ? req_act : !req_act; // R04
    assign link.reg_rdata = rdata_r;
    assign link.done_irq = done_r; // R11
    assign link.irq_code = code_r;
    assign sector_start = start_r;
    assign dma_busy = (state_r != S_IDLE);
endmodule

// >>> core/fddma_host_end.sv
// Host end: a DMA controller that programs the device, answers its
// requests with bus cycles and reports completion to software.
// Assumes software on the plain register port and one shared clock.
`timescale 1ns/1ps
module fddma_host_end import fddma_pkg::*; #(
    parameter int BURST_WORDS = WORDS_PER_SECTOR
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    fddma_if.host link,
    input wire logic [SW_AW-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic irq
);
    typedef enum logic [1:0] {H_IDLE, H_SET1, H_SET0, H_RUN} fddma_hst_e;

    generate
        if (BURST_WORDS < 1 || BURST_WORDS > 65535) begin : g_chk
            $error("BURST_WORDS out of range");
        end
    endgenerate

    fddma_hst_e st_r;
    logic [31:0] cfg_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic [31:0] words_r;
    logic [15:0] burst_r;
    logic [DATA_W-1:0] peek_r;
    logic peek_go_r;
    logic peek_sel_r;
    logic peek_wait_r;
    logic resume_r;
    logic rq_prev_r;
    logic irq_prev_r;
    logic [31:0] rdata_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic wr_r;
    logic rd_r;
    logic rq;
    logic rq_rise;
    logic done_rise;
    logic cyc;

    // Request seen at its active level, as chosen by the polarity bit
    assign rq = cfg_r[POL_BIT] ? link.transfer_request_out
                               : !link.transfer_request_out;
    assign rq_rise = rq && !rq_prev_r;
    assign done_rise = link.done_irq && !irq_prev_r;
    // Level mode reads while asserted; edge mode runs a counted burst
    assign cyc = (st_r == H_RUN) && !rd_r && !wr_r
                 && (cfg_r[EDGE_BIT] ? (burst_r != 16'h0000) : rq);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rq_prev_r <= 1'b0;
            irq_prev_r <= 1'b0;
        end else begin
            rq_prev_r <= rq;
            irq_prev_r <= link.done_irq;
        end
    end

    // Sequencer and device register accesses, one per cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= H_IDLE;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= CTRL0_OFS;
            wdata_r <= 16'h0000;
        end else begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            if (st_r == H_SET1) begin
                wr_r <= 1'b1;
                addr_r <= CTRL1_OFS;
                wdata_r <= {6'h00, cfg_r[CFG_REL_LSB +: REL_W]};
                st_r <= H_SET0;
            end else if (st_r == H_SET0) begin
                wr_r <= 1'b1;
                addr_r <= CTRL0_OFS;
                wdata_r <= {1'b1, 1'b0, cfg_r[EDGE_BIT], cfg_r[POL_BIT],
                            5'h00, cfg_r[SCNT_W-1:0]};
                st_r <= H_RUN;
            end else if (peek_go_r) begin
                rd_r <= 1'b1;
                addr_r <= peek_sel_r ? CTRL1_OFS : CTRL0_OFS;
            end else if (resume_r) begin
                // Rewrites the last peeked control word with pause clear
                wr_r <= 1'b1;
                addr_r <= CTRL0_OFS;
                wdata_r <= peek_r & ~(16'h0001 << PAUSE_BIT);
            end
            // Kept outside the chain so a peek or resume never hides
            // a start command or the one-cycle completion edge
            if (st_r == H_IDLE && sw_wr && sw_addr == H_CMD
                && sw_wdata[CMD_START]) begin
                st_r <= H_SET1;
            end
            if (st_r == H_RUN && done_rise) begin
                st_r <= H_IDLE;
            end
        end
    end

    // Software requests for peeks and resumes, held until served
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            peek_go_r <= 1'b0;
            peek_sel_r <= 1'b0;
            peek_wait_r <= 1'b0;
            resume_r <= 1'b0;
            peek_r <= 16'h0000;
        end else begin
            peek_wait_r <= rd_r;
            if (peek_wait_r) begin
                peek_r <= link.reg_rdata;
            end
            if (sw_wr && sw_addr == H_PEEK) begin
                peek_go_r <= 1'b1;
                peek_sel_r <= sw_wdata[0];
            end else if (st_r != H_SET1 && st_r != H_SET0) begin
                peek_go_r <= 1'b0;
            end
            if (sw_wr && sw_addr == H_CMD && sw_wdata[CMD_RESUME]) begin
                resume_r <= 1'b1;
            end else if (st_r != H_SET1 && st_r != H_SET0 && !peek_go_r) begin
                resume_r <= 1'b0;
            end
        end
    end

    // Burst length and word count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_r <= 16'h0000;
            words_r <= 32'h0000_0000;
        end else begin
            if (st_r == H_SET1) begin
                words_r <= 32'h0000_0000;
            end else if (cyc) begin
                words_r <= words_r + 32'h0000_0001;
            end
            if (st_r == H_RUN && rq_rise && cfg_r[EDGE_BIT]) begin
                burst_r <= 16'(BURST_WORDS);
            end else if (cyc && burst_r != 16'h0000) begin
                burst_r <= burst_r - 16'h0001;
            end
        end
    end

    // Configuration, sticky status (write one to clear, set wins), mask
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 32'h0000_0000;
            mask_r <= 3'h0;
            stat_r <= 3'h0;
        end else begin
            if (sw_wr && sw_addr == H_CFG) begin
                cfg_r <= sw_wdata;
            end
            if (sw_wr && sw_addr == H_MASK) begin
                mask_r <= sw_wdata[2:0];
            end
            stat_r <= (stat_r & ~((sw_wr && sw_addr == H_STAT)
                                  ? sw_wdata[2:0] : 3'h0))
                      | {peek_wait_r, rq_rise, done_rise};
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (sw_rd) begin
            unique case (sw_addr)
                H_CFG: rdata_r <= cfg_r;
                H_STAT: rdata_r <= {29'h0, stat_r};
                H_MASK: rdata_r <= {29'h0, mask_r};
                H_WORDS: rdata_r <= words_r;
                H_PEEK: rdata_r <= {16'h0000, peek_r};
                H_CMD: rdata_r <= {31'h0, st_r != H_IDLE};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign link.reg_addr = addr_r;
    assign link.reg_wdata = wdata_r;
    assign link.reg_wr = wr_r;
    assign link.reg_rd = rd_r;
    assign link.xfer_cyc = cyc;
    assign sw_rdata = rdata_r;
    assign irq = |(stat_r & mask_r);
endmodule

// >>> sim/fddma_sva.sv
// Checker on the link between the device end and the host end.
// Sees only the interface signals; the bench instantiates it once.
`timescale 1ns/1ps
module fddma_sva import fddma_pkg::*; #(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic xfer_cyc,
    input wire logic transfer_request_out,
    input wire logic done_irq,
    input wire logic [CODE_W-1:0] irq_code
);
    logic pol_r, edge_r, en_r, pause_r, rd0_r;
    logic [REL_W-1:0] rel_r;
    logic [15:0] act_cnt_r;
    logic wr0;
    logic act;
    assign wr0 = reg_wr && reg_addr == CTRL0_OFS;
    assign act = transfer_request_out == pol_r;

    // Mirror of control bits; hardware clears enable once done shows
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pol_r <= 1'b0;
            edge_r <= 1'b0;
            en_r <= 1'b0;
            rel_r <= '0;
        end else begin
            if (wr0) begin
                pol_r <= reg_wdata[POL_BIT];
                edge_r <= reg_wdata[EDGE_BIT];
            end
            en_r <= wr0 ? reg_wdata[EN_BIT] : (en_r && !done_irq);
            if (reg_wr && reg_addr == CTRL1_OFS)
                rel_r <= reg_wdata[REL_W-1:0];
        end
    end

    // Pause is only visible once read back, so it is learnt from reads
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pause_r <= 1'b0;
            rd0_r <= 1'b0;
        end else begin
            rd0_r <= reg_rd && reg_addr == CTRL0_OFS;
            if (wr0)
                pause_r <= pause_r && reg_wdata[PAUSE_BIT];
            else if (rd0_r && reg_rdata[PAUSE_BIT])
                pause_r <= 1'b1;
        end
    end

    // Length of the current active run of the request
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            act_cnt_r <= '0;
        else
            act_cnt_r <= act ? act_cnt_r + 16'h0001 : 16'h0000;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    pulse_len_a: assert property (
        edge_r && act |-> act_cnt_r < PULSE_CYCLES)
        else $error("request pulse longer than set");
    start_req_a: assert property (
        wr0 && reg_wdata[EN_BIT] && reg_wdata[EDGE_BIT] && !en_r && !pause_r
        |=> ##1 transfer_request_out == $past(reg_wdata[POL_BIT], 2))
        else $error("request not raised after enable");
    idle_level_a: assert property (
        !en_r && !$past(en_r) |-> transfer_request_out == !pol_r)
        else $error("request not idle while disabled");
    done_quiet_a: assert property (
        done_irq |-> transfer_request_out == !pol_r)
        else $error("request active after last sector");
    irq_code_a: assert property (
        irq_code == (done_irq ? IRQ_DMA_DONE : IRQ_NONE))
        else $error("interrupt code wrong");
    pause_halt_a: assert property (
        pause_r |-> transfer_request_out == !pol_r)
        else $error("request active while paused");
    rel_back_a: assert property (
        reg_rd && reg_addr == CTRL1_OFS |=> reg_rdata == {6'h00, rel_r})
        else $error("release count read back wrong");
    ctrl_back_a: assert property (
        reg_rd && reg_addr == CTRL0_OFS |=> reg_rdata[11:7] == 5'h00
        && reg_rdata[POL_BIT] == pol_r && reg_rdata[EDGE_BIT] == edge_r)
        else $error("control read back wrong");
    xfer_level_a: assert property (
        xfer_cyc && !edge_r |-> act)
        else $error("bus cycle without request in level mode");
endmodule

// >>> sim/flash_disk_dma_request_control_test.sv
// Bench: host end and device end joined by the link, driven from the
// software port and the flash-side strobes; one clock, no partner model.
`timescale 1ns/1ps
module flash_disk_dma_request_control_test import fddma_pkg::*;;
    localparam int PULSE = 2;
    logic ref_clk, arst_n, sw_wr, sw_rd, irq, cks_rd, ecc_flt, busy;
    logic [SW_AW-1:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, d;
    logic [REL_W-1:0] countdown;
    int fail_count, n_checks, v;
    fddma_if link();
    fddma_dev_end #(.PULSE_CYCLES(PULSE)) u_fddma_dev_end (
        .ref_clk(ref_clk), .arst_n(arst_n), .link(link),
        .flash_data_countdown(countdown), .checksum_read(cks_rd),
        .ecc_fault(ecc_flt), .sector_start(), .dma_busy(busy));
    fddma_host_end #(.BURST_WORDS(4)) u_fddma_host_end (
        .ref_clk(ref_clk), .arst_n(arst_n), .link(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq));
    fddma_sva #(.PULSE_CYCLES(PULSE)) u_fddma_sva (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
        .xfer_cyc(link.xfer_cyc), .irq_code(link.irq_code),
        .transfer_request_out(link.transfer_request_out),
        .done_irq(link.done_irq));

    function automatic logic [31:0] cfg(input logic [9:0] rel,
        input logic e, input logic p, input logic [6:0] sc);
        return {6'h00, rel, 2'h0, e, p, 5'h00, sc};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Software port cycles: strobes last one cycle, read data next cycle
    task automatic sw_write(input logic [7:0] a, input logic [31:0] w);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= w;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [7:0] a, output logic [31:0] r);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1;
        r = sw_rdata;
    endtask

    // Fetch a device control word through the host, polling ready
    task automatic peek(input logic sel, output logic [31:0] r);
        int i;
        sw_write(H_PEEK, {31'h0, sel});
        r = '0;
        for (i = 0; i < 50 && r[2] !== 1'b1; i++)
            sw_read(H_STAT, r);
        sw_write(H_STAT, 32'h4);
        sw_read(H_PEEK, r);
    endtask

    task automatic wait_lvl(input logic lvl);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            #1;
            // Busy guard: an old idle level can match before the
            // new control word lands
            if (busy === 1'b1 && link.transfer_request_out === lvl)
                break;
        end
        chk("request wait", {busy, link.transfer_request_out}, {1'b1, lvl});
    endtask

    // One sector: measure the request run, then the checksum strobe
    task automatic sector(input logic act, input logic fault);
        int n;
        wait_lvl(act);
        n = 1;
        @(posedge ref_clk);
        #1;
        while (link.transfer_request_out === act && n < 200) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        chk("pulse length", n, PULSE);
        @(posedge ref_clk);
        cks_rd <= 1'b1;
        ecc_flt <= fault;
        @(posedge ref_clk);
        cks_rd <= 1'b0;
        ecc_flt <= 1'b0;
    endtask

    task automatic quiet(input int n, input logic idle);
        int i;
        int bad;
        bad = 0;
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (link.transfer_request_out !== idle)
                bad++;
        end
        chk("request quiet", bad, 0);
    endtask

    task automatic done_chk();
        repeat (4) @(posedge ref_clk);
        #1;
        chk("done flag", link.done_irq, 1'b1);
        chk("irq code", link.irq_code, IRQ_DMA_DONE);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Generous bound: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    initial begin
        arst_n = 1'b0;
        sw_addr = '0;
        sw_wdata = '0;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        countdown = 10'h3FF;
        cks_rd = 1'b0;
        ecc_flt = 1'b0;
        fail_count = 0;
        n_checks = 0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        sw_read(8'h1C, d);
        chk("unmapped read", d, 32'h0);
        peek(1'b0, d);
        chk("ctrl0 reset", d, {16'h0000, CTRL_RST});
        peek(1'b1, d);
        chk("ctrl1 reset", d, 32'h0);
        quiet(20, 1'b1);
        $display("test reset_idle done");
        // Edge mode, active high, two sectors
        sw_write(H_MASK, 32'h1);
        sw_write(H_CFG, cfg(10'h000, 1'b1, 1'b1, 7'h01));
        sw_write(H_CMD, 32'h1);
        sector(1'b1, 1'b0);
        sector(1'b1, 1'b0);
        done_chk();
        chk("irq raised", irq, 1'b1);
        sw_read(H_WORDS, d);
        chk("words moved", d, 32'h8);
        quiet(20, 1'b0);
        peek(1'b0, d);
        chk("ctrl0 after done", d, 32'h3000);
        sw_write(H_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq masked", irq, 1'b0);
        sw_write(H_MASK, 32'h1);
        sw_write(H_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq cleared", irq, 1'b0);
        $display("test edge_mode done");
        // Level mode, active low, release at count 20
        sw_write(H_CFG, cfg(10'h014, 1'b0, 1'b0, 7'h00));
        sw_write(H_CMD, 32'h1);
        wait_lvl(1'b0);
        for (v = 24; v >= 20; v--) begin
            @(posedge ref_clk);
            countdown <= 10'(v);
            #1;
            chk("level release", link.transfer_request_out, v == 20);
        end
        @(posedge ref_clk);
        cks_rd <= 1'b1;
        @(posedge ref_clk);
        cks_rd <= 1'b0;
        done_chk();
        $display("test level_mode done");
        // Checksum fault on first of three sectors, then resume
        sw_write(H_CFG, cfg(10'h000, 1'b1, 1'b0, 7'h02));
        sw_write(H_CMD, 32'h1);
        sector(1'b0, 1'b1);
        peek(1'b0, d);
        chk("paused count", d, 32'hE001);
        quiet(20, 1'b1);
        sw_write(H_CMD, 32'h2);
        sector(1'b0, 1'b0);
        sector(1'b0, 1'b0);
        done_chk();
        $display("test pause_resume done");
        summarize();
    end
endmodule
